// ===== hbgc_pkg.sv
/*
  hbgc_pkg: constants and types shared by the half-bridge gate control.
  assumes a 40 MHz device clock and four half-bridges.
*/
`default_nettype none
package hbgc_pkg;

  // ==========================================================
  // geometry and clock
  localparam int NUM_HB        = 4;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CNT_W         = 16;
  localparam int PIN_W         = 18;

  // ==========================================================
  // timing (ns) and derived cycle counts
  localparam int CMD_DELAY_MAX_NS  = 3000;
  localparam int CMD_DELAY_MAX_CYC = CMD_DELAY_MAX_NS / CLK_PERIOD_NS;
  localparam int T_CCP_NS          = 500;
  localparam int T_CCP_CYC         =
    (T_CCP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_TURN_ON_NS      = 2000;
  localparam int T_TURN_ON_CYC     =
    (T_TURN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // mode encoding and current codes
  localparam logic [1:0] MODE_OFF       = 2'h0;
  localparam logic [1:0] MODE_LS        = 2'h1;
  localparam logic [1:0] MODE_HS        = 2'h2;
  localparam logic [1:0] MODE_RSV       = 2'h3;
  localparam logic [3:0] HOLD_LOW_CODE  = 4'h4;
  localparam logic [3:0] HOLD_HIGH_CODE = 4'h6;
  localparam logic [4:0] HARD_OFF_CODE  = 5'h1f;

  // ==========================================================
  // reset values
  localparam logic       RST_PASSIVE     = 1'b1;
  localparam logic [1:0] RST_MODE        = 2'h0;
  localparam logic [3:0] RST_STATIC_CODE = 4'h0;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_OFF    = 2'h0,
    ST_CHARGE = 2'h1,
    ST_HOLD   = 2'h3,
    ST_CCP    = 2'h2
  } hbgc_state_t;

  // on=1 sources the step in code, on=0 sinks it
  typedef struct packed {
    logic       on;
    logic [4:0] code;
  } hbgc_gate_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] code;
  } hbgc_hb_cfg_t;

  typedef struct packed {
    logic vs_ov;
    logic vs_uv;
    logic cp_uv;
    logic ot;
    logic fail_safe;
  } hbgc_fault_t;

endpackage : hbgc_pkg
`default_nettype wire

// ===== hbgc_top.sv
/*
  hbgc_top: control logic for eight gate drivers in four half-bridges.
  assumes serial-interface logic on mclk_i presents configuration and
  pulses cfg_commit_i once the chip-select rising edge is synchronised;
  fault, enable and pwm levels arrive as asynchronous pins.

*/
`timescale 1ns/1ps
`default_nettype none
module hbgc_top #(
  parameter int CCP_CYC     = hbgc_pkg::T_CCP_CYC,
  parameter int TURN_ON_CYC = hbgc_pkg::T_TURN_ON_CYC
) (
  input  wire  logic                  mclk_i,        // device clock
  input  wire  logic                  rst_n_i,       // sync reset, low
  input  wire  logic                  ce_i,          // clock enable
  input  wire  logic                  en_i,          // enable pin
  input  wire  hbgc_pkg::hbgc_fault_t fault_i,       // global fault pins
  input  wire  logic [3:0]            vds_ov_i,      // drain-source ov
  input  wire  logic [3:0]            overcurrent_i, // overcurrent
  input  wire  logic [3:0]            pwm_level_i,   // pwm per bridge
  input  wire  logic [3:0]            pwm_mapped_i,  // bridge on pwm
  input  wire  logic                  cfg_commit_i,  // apply config
  input  wire  logic                  passive_select_i, // new select
  input  wire  hbgc_pkg::hbgc_hb_cfg_t [3:0] half_bridge_cfg_i, // cfg
  input  wire  logic                  hold_current_select_i, // hold
  input  wire  logic                  overcurrent_shutdown_enable_i, // oc
  output logic                        active_mode_o, // drivers active
  output logic                        passive_select_o, // committed
  output logic [3:0]                  high_side_switch_o, // hs on
  output logic [3:0]                  low_side_switch_o,  // ls on
  output hbgc_pkg::hbgc_gate_t [3:0]  hs_drive_o,    // hs current
  output hbgc_pkg::hbgc_gate_t [3:0]  ls_drive_o,    // ls current
  output logic [3:0]                  fault_off_o    // latched trip
);
  import hbgc_pkg::*;

  // ==========================================================
  // pin synchroniser: three stages, accept on agreement
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pin_q;
  logic [PIN_W-1:0] next_pin_q;

  assign pin_raw    = {en_i, fault_i, vds_ov_i, overcurrent_i,
                       pwm_level_i};
  assign next_pin_q = (sync2 & sync3) | (pin_q & (sync2 ^ sync3));

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_q <= '0;
    end else if (ce_i) begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_q <= next_pin_q;
    end
  end

  wire              en_s     = pin_q[17];
  hbgc_fault_t      fault_s;
  wire [3:0]        vds_s    = pin_q[11:8];
  wire [3:0]        oc_s     = pin_q[7:4];
  wire [3:0]        pwm_s    = pin_q[3:0];
  assign fault_s = pin_q[16:12];

  // ==========================================================
  // committed configuration
  logic                    pass_q;
  hbgc_hb_cfg_t [3:0]      cfg_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pass_q <= RST_PASSIVE;
      for (int i = 0; i < NUM_HB; i++) begin
        cfg_q[i].mode <= RST_MODE;
        cfg_q[i].code <= RST_STATIC_CODE;
      end
    end else if (ce_i && cfg_commit_i) begin
      pass_q <= passive_select_i;
      cfg_q  <= half_bridge_cfg_i;
    end
  end

  // ==========================================================
  // operating mode decode
  logic [3:0] hb_wants_on;
  logic       any_on_mode;
  logic       active_mode;
  logic       global_fault;
  logic       drive_ok;
  logic [3:0] hold_code;

  for (genvar b = 0; b < NUM_HB; b++) begin : g_mode
    assign hb_wants_on[b] = (cfg_q[b].mode == MODE_LS) ||
                            (cfg_q[b].mode == MODE_HS);
  end

  assign any_on_mode  = |hb_wants_on;
  // parked select overridden by an on mode
  assign active_mode  = en_s && (!pass_q || any_on_mode);
  assign global_fault = fault_s.vs_ov || fault_s.vs_uv ||
                        fault_s.cp_uv || fault_s.ot ||
                        fault_s.fail_safe;
  assign drive_ok     = active_mode && !global_fault;
  assign hold_code    = hold_current_select_i ? HOLD_HIGH_CODE
                                              : HOLD_LOW_CODE;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      active_mode_o    <= 1'b0;
      passive_select_o <= RST_PASSIVE;
    end else if (ce_i) begin
      active_mode_o    <= active_mode;
      passive_select_o <= pass_q;
    end
  end

  // ==========================================================
  // per half-bridge sequencer
  // one sequencer per half-bridge
  for (genvar b = 0; b < NUM_HB; b++) begin : g_hb
    hbgc_state_t      state;
    hbgc_state_t      next_state;
    logic             side_hs;
    logic             next_side_hs;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             trip;
    logic             trip_set;
    logic             trip_clr;
    logic             want_on;
    logic             want_hs;
    logic             side_change;
    logic             cnt_zero;
    hbgc_gate_t       next_hs;
    hbgc_gate_t       next_ls;
    hbgc_gate_t       static_sink;
    hbgc_gate_t       static_src;
    hbgc_gate_t       hold_sink;
    hbgc_gate_t       hold_src;
    hbgc_gate_t       hard_off;

    assign trip_set = active_mode &&
                      (vds_s[b] ||
                       (oc_s[b] && overcurrent_shutdown_enable_i));
    assign trip_clr = cfg_commit_i && ce_i &&
                      !((half_bridge_cfg_i[b].mode == MODE_LS) ||
                        (half_bridge_cfg_i[b].mode == MODE_HS));

    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        trip <= 1'b0;
      end else if (ce_i) begin
        trip <= trip_set || (trip && !trip_clr);
      end
    end

    // mode decode, 11 keeps both off
    assign want_on = drive_ok && hb_wants_on[b] && !trip &&
                     !trip_set && (!pwm_mapped_i[b] || pwm_s[b]);
    assign want_hs = (cfg_q[b].mode == MODE_HS);
    assign side_change = (want_hs != side_hs);
    assign cnt_zero    = (cnt == '0);

    // static step from the bridge's code
    assign static_sink = '{on: 1'b0, code: {1'b0, cfg_q[b].code}};
    assign static_src  = '{on: 1'b1, code: {1'b0, cfg_q[b].code}};
    assign hold_sink   = '{on: 1'b0, code: {1'b0, hold_code}};
    assign hold_src    = '{on: 1'b1, code: {1'b0, hold_code}};
    // hard-off sink on the opposite side
    assign hard_off    = '{on: 1'b0, code: HARD_OFF_CODE};

    always_comb begin
      next_state   = state;
      next_side_hs = side_hs;
      next_cnt     = cnt;
      case (state)
        ST_OFF: begin
          if (want_on) begin
            next_state   = ST_CHARGE;
            next_side_hs = want_hs;
            next_cnt     = CNT_W'(TURN_ON_CYC - 1);
          end
        end
        ST_CHARGE: begin
          if (!want_on || side_change) begin
            next_state = ST_CCP;
            next_cnt   = CNT_W'(CCP_CYC - 1);
          end else if (cnt_zero) begin
            next_state = ST_HOLD;
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
        ST_HOLD: begin
          if (!want_on || side_change) begin
            next_state = ST_CCP;
            next_cnt   = CNT_W'(CCP_CYC - 1);
          end
        end
        ST_CCP: begin
          if (!cnt_zero) begin
            next_cnt = cnt - 1'b1;
          end else if (want_on) begin
            next_state   = ST_CHARGE;
            next_side_hs = want_hs;
            next_cnt     = CNT_W'(TURN_ON_CYC - 1);
          end else begin
            next_state = ST_OFF;
          end
        end
        default: begin
          next_state = ST_OFF;
        end
      endcase
      // passive drivers leave no sequence running
      if (!active_mode) begin
        next_state = ST_OFF;
        next_cnt   = '0;
      end
    end

    // gate currents follow the next state so outputs stay aligned
    always_comb begin
      case (next_state)
        ST_CHARGE: begin
          next_hs = next_side_hs ? static_src : hard_off;
          next_ls = next_side_hs ? hard_off : static_src;
        end
        ST_HOLD: begin
          next_hs = next_side_hs ? hold_src : hold_sink;
          next_ls = next_side_hs ? hold_sink : hold_src;
        end
        ST_CCP: begin
          next_hs = static_sink;
          next_ls = static_sink;
        end
        default: begin
          next_hs = hold_sink;
          next_ls = hold_sink;
        end
      endcase
    end

    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        state                 <= ST_OFF;
        side_hs               <= 1'b0;
        cnt                   <= '0;
        hs_drive_o[b]         <= '{on: 1'b0, code: {1'b0, HOLD_LOW_CODE}};
        ls_drive_o[b]         <= '{on: 1'b0, code: {1'b0, HOLD_LOW_CODE}};
        high_side_switch_o[b] <= 1'b0;
        low_side_switch_o[b]  <= 1'b0;
        fault_off_o[b]        <= 1'b0;
      end else if (ce_i) begin
        state                 <= next_state;
        side_hs               <= next_side_hs;
        cnt                   <= next_cnt;
        hs_drive_o[b]         <= next_hs;
        ls_drive_o[b]         <= next_ls;
        high_side_switch_o[b] <= next_hs.on;
        low_side_switch_o[b]  <= next_ls.on;
        fault_off_o[b]        <= trip_set || (trip && !trip_clr);
      end
    end
  end

endmodule : hbgc_top
`default_nettype wire

// ===== hbgc_monitor.sv
/*
  hbgc_monitor: port assertions for hbgc_top.
  assumes the single mclk_i domain; bound to every hbgc_top instance.
*/
`timescale 1ns/1ps
`default_nettype none
module hbgc_monitor #(
  parameter int CCP_CYC     = 2,
  parameter int TURN_ON_CYC = 3
) (
  input wire logic                         mclk_i,       // clock
  input wire logic                         rst_n_i,      // reset
  input wire logic                         ce_i,         // enable
  input wire logic                         en_i,         // enable pin
  input wire hbgc_pkg::hbgc_fault_t        fault_i,      // faults
  input wire logic                         cfg_commit_i, // commit
  input wire logic                         passive_select_i, // select
  input wire hbgc_pkg::hbgc_hb_cfg_t [3:0] half_bridge_cfg_i, // cfg
  input wire logic                         hold_current_select_i, // hold
  input wire logic                         active_mode_o,    // active
  input wire logic                         passive_select_o, // select
  input wire logic [3:0]                   high_side_switch_o, // hs
  input wire logic [3:0]                   low_side_switch_o,  // ls
  input wire hbgc_pkg::hbgc_gate_t [3:0]   hs_drive_o,   // hs drive
  input wire hbgc_pkg::hbgc_gate_t [3:0]   ls_drive_o    // ls drive
);
  import hbgc_pkg::*;
  logic [3:0] hold_cd;
  logic       park0;
  assign hold_cd = hold_current_select_i ? HOLD_HIGH_CODE : HOLD_LOW_CODE;
  assign park0   = half_bridge_cfg_i[0].mode[0] ==
                   half_bridge_cfg_i[0].mode[1];
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // turn-on steps
  sequence hs_on_s;
    $rose(high_side_switch_o[0]);
  endsequence
  sequence charged_s;
    hs_on_s ##TURN_ON_CYC high_side_switch_o[0];
  endsequence
  // ==========================================================
  // assertions
  reset_state_a: assert property (disable iff (1'b0) !rst_n_i |=>
    passive_select_o && !active_mode_o && high_side_switch_o == 4'h0)
    else $error("reset state wrong");
  no_shoot_a: assert property (
    (high_side_switch_o & low_side_switch_o) == 4'h0)
    else $error("both switches on");
  // committed select shows on the output one flop later
  sel_commit_a: assert property (ce_i && cfg_commit_i |=> ##1
    passive_select_o == $past(passive_select_i, 2))
    else $error("passive select not taken");
  enable_off_a: assert property ((!en_i && ce_i)[*8] |->
    !active_mode_o)
    else $error("active with enable low");
  enable_on_a: assert property (
    (en_i && ce_i && !passive_select_o)[*8] |-> active_mode_o)
    else $error("not active after select cleared");
  passive_sw_a: assert property ((!active_mode_o)[*2] |->
    high_side_switch_o == 4'h0 && low_side_switch_o == 4'h0)
    else $error("switch on while passive");
  hard_off_a: assert property (hs_on_s |->
    ls_drive_o[0] == {1'b0, HARD_OFF_CODE})
    else $error("opposite gate not hard off");
  hold_step_a: assert property (charged_s |->
    hs_drive_o[0] == {1'b1, 1'b0, hold_cd} &&
    ls_drive_o[0] == {1'b0, 1'b0, hold_cd})
    else $error("hold step wrong");
  park_off_a: assert property (ce_i && cfg_commit_i && park0 |->
    ##[1:120] !high_side_switch_o[0] && !low_side_switch_o[0])
    else $error("parked bridge not off");
  fault_off_a: assert property ((ce_i && |fault_i)[*8] |->
    high_side_switch_o == 4'h0 && low_side_switch_o == 4'h0)
    else $error("switch on during fault");
endmodule : hbgc_monitor
bind hbgc_top hbgc_monitor #(.CCP_CYC(CCP_CYC), .TURN_ON_CYC(TURN_ON_CYC))
  i_hbgc_monitor (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .en_i(en_i), .fault_i(fault_i), .cfg_commit_i(cfg_commit_i),
  .passive_select_i(passive_select_i),
  .half_bridge_cfg_i(half_bridge_cfg_i),
  .hold_current_select_i(hold_current_select_i),
  .active_mode_o(active_mode_o), .passive_select_o(passive_select_o),
  .high_side_switch_o(high_side_switch_o),
  .low_side_switch_o(low_side_switch_o),
  .hs_drive_o(hs_drive_o), .ls_drive_o(ls_drive_o));
`default_nettype wire

// ===== hbgc_gate_model.sv
/*
  hbgc_gate_model: crude gate charge of eight external switches.
  assumes drive structs from hbgc_top on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hbgc_gate_model (
  input  wire logic                       mclk_i,     // clock
  input  wire hbgc_pkg::hbgc_gate_t [7:0] drive_i,    // hs 3:0, ls 7:4
  output var  logic                       both_on_o   // sticky overlap
);
  import hbgc_pkg::*;
  logic [2:0] lvl [8];
  initial both_on_o = 1'b0;
  always @(posedge mclk_i) begin
    for (int g = 0; g < 8; g++) begin
      if (drive_i[g].on) begin
        if (lvl[g] != 3'h7) begin
          lvl[g] <= lvl[g] + 3'h1;
        end
      end else if (drive_i[g].code == HARD_OFF_CODE) begin
        lvl[g] <= 3'h0;
      end else if (lvl[g] != 3'h0) begin
        lvl[g] <= lvl[g] - 3'h1;
      end
    end
    for (int b = 0; b < 4; b++) begin
      if (lvl[b][2] && lvl[b+4][2]) begin
        both_on_o <= 1'b1;
      end
    end
  end
  initial for (int g = 0; g < 8; g++) lvl[g] = 3'h0;
endmodule : hbgc_gate_model
`default_nettype wire

// ===== tb_hbgc_top.sv
/*
  tb_hbgc_top: directed test of hbgc_top with a gate model.
  assumes small CCP and turn-on counts; pwm unused.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_hbgc_top;
  import hbgc_pkg::*;
  logic               mclk_i = 0, rst_n_i = 0, en_i = 0, commit = 0;
  logic               ps = 1, hold = 0, overcurrent_shutdown_enable = 0, ce = 1, act, pso, both_on;
  hbgc_fault_t        fault = '0;
  logic [3:0]         vds = '0, oc = '0, hs_sw, ls_sw, foff, h, l;
  logic [7:0]         md;
  hbgc_hb_cfg_t [3:0] cfg = '0;
  hbgc_gate_t [3:0]   hs_dr, ls_dr;
  int                 miscompares = 0, n_checks = 0;
  always #12.5 mclk_i = ~mclk_i;
  hbgc_top #(.CCP_CYC(2), .TURN_ON_CYC(3)) i_hbgc_top (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .ce_i(ce), .en_i(en_i), .fault_i(fault),
    .vds_ov_i(vds), .overcurrent_i(oc), .pwm_level_i(4'h0),
    .pwm_mapped_i(4'h0), .cfg_commit_i(commit), .passive_select_i(ps),
    .half_bridge_cfg_i(cfg), .hold_current_select_i(hold),
    .overcurrent_shutdown_enable_i(overcurrent_shutdown_enable), .active_mode_o(act),
    .passive_select_o(pso), .high_side_switch_o(hs_sw),
    .low_side_switch_o(ls_sw), .hs_drive_o(hs_dr), .ls_drive_o(ls_dr),
    .fault_off_o(foff));
  hbgc_gate_model i_hbgc_gate_model (.mclk_i(mclk_i),
    .drive_i({ls_dr, hs_dr}), .both_on_o(both_on));
  // ==========================================================
  // tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task sw(input logic [3:0] hx, input logic [3:0] lx);
    chk(hs_sw, hx);
    chk(ls_sw, lx);
  endtask : sw
  task wt(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : wt
  task cmt(input logic p, input logic [7:0] m, input logic [3:0] c);
    @(posedge mclk_i);
    ps <= p;
    commit <= 1'b1;
    for (int b = 0; b < 4; b++) cfg[b] <= {m[2*b +: 2], c};
    @(posedge mclk_i);
    commit <= 1'b0;
  endtask : cmt
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // ==========================================================
  // sequence
  initial begin
    #100us;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    #1;
    chk({pso, act, hs_dr[0]}, {2'h2, 1'b0, 5'h04});
    @(posedge mclk_i);
    en_i <= 1'b1;
    cmt(1, 8'h00, 4'h0); wt(10); chk(act, 0);
    cmt(1, 8'h01, 4'h3); wt(10); chk(act, 1);
    sw(4'h0, 4'h1);
    // park every bridge before clearing passive select
    cmt(1, 8'hc0, 4'h3); wt(10); chk(act, 0);
    cmt(0, 8'hc0, 4'h3); wt(10); chk(act, 1);
    chk(pso, 0);
    for (int m = 0; m < 4; m++) begin
      for (int b = 0; b < 4; b++) md[2*b +: 2] = 2'(m + b);
      for (int b = 0; b < 4; b++) begin
        h[b] = (md[2*b +: 2] == 2'h2);
        l[b] = (md[2*b +: 2] == 2'h1);
      end
      @(posedge mclk_i);
      hold <= m[0];
      cmt(0, md, 4'h5); wt(12); sw(h, l);
      for (int b = 0; b < 4; b++) begin
        chk(hs_dr[b], {h[b], 1'b0, m[0] ? 4'h6 : 4'h4});
      end
    end
    foreach (md[c]) if (c < 2) begin
      cmt(0, 8'h00, c ? 4'hf : 4'h0); wt(10);
      cmt(0, 8'h02, c ? 4'hf : 4'h0); wt(2);
      chk(hs_dr[0], {2'h2, c ? 4'hf : 4'h0});
      chk(ls_dr[0], {1'b0, 5'h1f});
    end
    wt(10);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk_i);
      fault <= hbgc_fault_t'(5'(1 << i));
      wt(10); sw(4'h0, 4'h0);
      @(posedge mclk_i);
      fault <= '0;
      wt(12); sw(4'h1, 4'h0);
    end
    @(posedge mclk_i);
    vds <= 4'h1;
    wt(10); sw(4'h0, 4'h0); chk(foff, 4'h1);
    @(posedge mclk_i);
    vds <= 4'h0;
    // let the pin clear through sync, else the set beats the clear
    wt(6);
    cmt(0, 8'h00, 4'h0);
    wt(4);
    chk(foff, 4'h0);
    cmt(0, 8'h02, 4'h0);
    wt(10);
    sw(4'h1, 4'h0);
    @(posedge mclk_i);
    oc <= 4'h1;
    wt(10); sw(4'h1, 4'h0);
    @(posedge mclk_i);
    overcurrent_shutdown_enable <= 1'b1;
    wt(10); sw(4'h0, 4'h0);
    // clock enable low freezes every flop, enable pin included
    @(posedge mclk_i);
    ce   <= 1'b0;
    en_i <= 1'b0;
    wt(10);
    chk(act, 1);
    @(posedge mclk_i);
    ce <= 1'b1;
    wt(10);
    chk(act, 0);
    sw(4'h0, 4'h0);
    chk(both_on, 0);
    end_sim();
  end
endmodule : tb_hbgc_top
`default_nettype wire
